// ==== core/spn_pkg.sv ====
package spn_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_STATION = 8'h04;
   localparam logic [7:0] OFS_RTS     = 8'h08;
   localparam logic [7:0] OFS_TMO     = 8'h0C;
   localparam logic [7:0] OFS_TXD     = 8'h10;
   localparam logic [7:0] OFS_RXD     = 8'h14;
   localparam logic [7:0] OFS_STAT    = 8'h18;
   localparam logic [7:0] OFS_CMD     = 8'h1C;
   // CTRL fields
   localparam int CTRL_BAUD_LSB = 0;
   localparam int CTRL_STOP2    = 3;
   localparam int CTRL_PAR_LSB  = 4;
   localparam int CTRL_PROTO    = 6;
   localparam int CTRL_ASCII    = 7;
   localparam int CTRL_IF422    = 8;
   localparam logic [8:0] CTRL_RESET = 9'h002;
   localparam logic [15:0] TMO_RESET = 16'h0064;
   // CMD bits
   localparam int CMD_MASTER = 0;
   localparam int CMD_TXGO   = 1;
   localparam int CMD_TXLAST = 2;
   localparam int CMD_CLRERR = 3;
   // STAT bits
   localparam int ST_TXRDY  = 0;
   localparam int ST_RXVAL  = 1;
   localparam int ST_PERR   = 2;
   localparam int ST_FERR   = 3;
   localparam int ST_TMOERR = 4;
   localparam int ST_MASTER = 5;
   localparam int ST_RTS    = 6;
   localparam int ST_RXADR  = 7;
   // Station numbers
   localparam logic [7:0] STN_MASTER  = 8'h01;
   localparam logic [7:0] STN_MAX     = 8'h5A;
   // Parity codes
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD  = 2'h2;
   // Clock and oversampled bit rates
   localparam int CLK_HZ   = 10_000_000;
   localparam int OVS      = 16;
   localparam int BAUD_N   = 5;
   localparam int BAUD_TAB [BAUD_N] = '{2400, 4800, 9600, 19200, 38400};
   localparam int MS_US    = 1000;
   localparam int TICK_NS  = 1_000_000;
   localparam int CYC_PER_MS = CLK_HZ / MS_US;
   localparam int DATA_BITS = 8;
   localparam int BYTE_W   = 8;
   typedef enum logic {PROTO_RTU, PROTO_ALT} spn_proto_t;

   function automatic logic [15:0] spn_div(input logic [2:0] sel);
      int idx;
      idx = (sel < 3'(BAUD_N)) ? int'(sel) : BAUD_N - 1;
      spn_div = 16'(CLK_HZ / (BAUD_TAB[idx] * OVS) - 1);
   endfunction

   function automatic logic spn_par(input logic [7:0] d, input logic [1:0] mode);
      spn_par = (mode == PAR_ODD) ? ~(^d) : (^d);
   endfunction
endpackage

// ==== core/spn_tx.sv ====
`timescale 1ns/1ns
module spn_tx (
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Timing and format
   input  wire logic       tick16,
   input  wire logic       stop2,
   input  wire logic [1:0] par,
   // Character
   input  wire logic       start,
   input  wire logic [7:0] data,
   output logic            busy,
   output logic            txd
);
   typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} spn_txs_t;
   spn_txs_t   st;
   logic [3:0] ph;
   logic [2:0] bitn;
   logic [7:0] sh;
   logic       stopn;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st    <= T_IDLE;
         ph    <= 4'h0;
         bitn  <= 3'h0;
         sh    <= 8'h00;
         stopn <= 1'b0;
         txd   <= 1'b1;
      end else if (st == T_IDLE) begin
         txd <= 1'b1;
         if (start) begin
            sh <= data;
            st <= T_START;
            ph <= 4'h0;
            txd <= 1'b0;
         end
      end else if (tick16) begin
         ph <= ph + 4'h1;
         if (ph == 4'hF) begin
            unique case (st)
               T_START: begin
                  st <= T_DATA;
                  bitn <= 3'h0;
                  txd <= sh[0]; // LSB first [RQ21]
               end
               T_DATA: begin
                  if (bitn == 3'(spn_pkg::DATA_BITS - 1)) begin
                     if (par != spn_pkg::PAR_NONE) begin
                        st <= T_PAR;
                        txd <= spn_pkg::spn_par(sh, par); // [RQ6]
                     end else begin
                        st <= T_STOP;
                        stopn <= stop2;
                        txd <= 1'b1;
                     end
                  end else begin
                     bitn <= bitn + 3'h1;
                     txd <= sh[bitn + 3'h1];
                  end
               end
               T_PAR: begin
                  st <= T_STOP;
                  stopn <= stop2; // [RQ5]
                  txd <= 1'b1;
               end
               T_STOP: begin
                  if (stopn) stopn <= 1'b0;
                  else st <= T_IDLE;
               end
               default: st <= T_IDLE;
            endcase
         end
      end
   end

   assign busy = (st != T_IDLE);
endmodule

// ==== core/spn_rx.sv ====
`timescale 1ns/1ns
module spn_rx (
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Timing and format
   input  wire logic       tick16,
   input  wire logic [1:0] par,
   input  wire logic       rxd,
   // Character out
   output logic            done,
   output logic [7:0]      data,
   output logic            perr,
   output logic            ferr
);
   typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} spn_rxs_t;
   spn_rxs_t   st;
   logic [3:0] ph;
   logic [2:0] bitn;
   logic       pbit;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= R_IDLE;
         ph <= 4'h0;
         bitn <= 3'h0;
         pbit <= 1'b0;
         data <= 8'h00;
         done <= 1'b0;
         perr <= 1'b0;
         ferr <= 1'b0;
      end else begin
         done <= 1'b0;
         if (tick16) begin
            ph <= ph + 4'h1;
            unique case (st)
               R_IDLE: if (!rxd) begin
                  st <= R_START;
                  ph <= 4'h1;
               end
               R_START: if (ph == 4'h7) begin
                  if (rxd) st <= R_IDLE;
                  else begin
                     st <= R_DATA;
                     ph <= 4'h8;
                     bitn <= 3'h0;
                  end
               end
               R_DATA: if (ph == 4'h7) begin
                  data <= {rxd, data[7:1]};
                  if (bitn == 3'(spn_pkg::DATA_BITS - 1))
                     st <= (par != spn_pkg::PAR_NONE) ? R_PAR : R_STOP;
                  bitn <= bitn + 3'h1;
               end
               R_PAR: if (ph == 4'h7) begin
                  pbit <= rxd;
                  st <= R_STOP;
               end
               R_STOP: if (ph == 4'h7) begin
                  st <= R_IDLE;
                  done <= 1'b1;
                  ferr <= ~rxd;
                  perr <= (par != spn_pkg::PAR_NONE) &&
                          (pbit != spn_pkg::spn_par(data, par)); // [RQ6]
               end
               default: st <= R_IDLE;
            endcase
         end
      end
   end
endmodule

// ==== core/spn_port.sv ====
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
// What the document requires
// RQ1: Port runs master or slave, either protocol
// RQ2: MODBUS selection uses RTU binary frames
// RQ3: Rates 2400 to 38400 baud selectable
// RQ4: All network devices share one rate
// RQ5: One or two stop bits appended
// RQ6: None, even or odd parity generated, checked
// RQ7: Wait RTS-on delay before first character
// RQ8: Hold RTS for RTS-off delay after last
// RQ9: Response timeout after request logs error
// RQ10: Station number 1 means network master
// RQ11: Slave station numbers span 1 to 90
// RQ12: Slave station numbers unique on network
// RQ13: After reset port acts as slave
// RQ14: Master transaction done returns to slave
// RQ15: Alternate protocol uses hex or ASCII format
// RQ16: First port drives RS-232 or RS-422 only
// RQ17: Host issues needed read and write commands
// RQ18: Multi-drop network holds 2 to 248 devices
// RQ19: Slave serves RTU requests without program; the port only flags a first-byte station match, the host must reply
// RQ20: Divider from system clock, defaults on reset
// RQ21: RTU characters eight bits, LSB first
module spn_port #(
   parameter int TMO_MS_MAX = 65535
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Serial line, RS-232 side
   output logic             txd232,
   input  wire logic        rxd232,
   // Serial line, RS-422 side
   output logic             txd422,
   output logic             txd422_oe,
   input  wire logic        rxd422,
   // Modem control
   output logic             rts
);
   logic [8:0]  ctrl_reg;
   logic [7:0]  stn_reg;
   logic [15:0] rts_reg;
   logic [15:0] tmo_reg;
   logic [7:0]  txd_reg;
   logic [7:0]  rxd_reg;
   logic        txfull_reg;
   logic        rxval_reg;
   logic        perr_reg;
   logic        ferr_reg;
   logic        tmoerr_reg;
   logic        master_reg;
   logic        last_reg;
   logic        rxadr_reg;
   logic        rxfirst_reg;
   logic        ap_we;
   logic        ap_re;
   logic [7:0]  ap_adr;

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_we  <= 1'b0;
         ap_re  <= 1'b0;
         ap_adr <= 8'h00;
      end else if (hready) begin
         ap_we  <= hsel & htrans[1] & hwrite;
         ap_re  <= hsel & htrans[1] & ~hwrite;
         ap_adr <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         // One wait state on reads, so read data follow a write just before
         hreadyout <= !(hready && hsel && htrans[1] && !hwrite);
         hresp     <= 1'b0;
      end
   end

   wire wr = ap_we;
   wire [1:0] par = ctrl_reg[spn_pkg::CTRL_PAR_LSB +: 2];
   wire cmd_wr = wr && ap_adr == spn_pkg::OFS_CMD;

   // Configuration defaults on reset [RQ20]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= spn_pkg::CTRL_RESET;
         stn_reg  <= spn_pkg::STN_MASTER;
         rts_reg  <= 16'h0000;
         tmo_reg  <= spn_pkg::TMO_RESET;
      end else if (wr) begin
         unique case (ap_adr)
            spn_pkg::OFS_CTRL:    ctrl_reg <= hwdata[8:0];
            spn_pkg::OFS_STATION:
               if (hwdata[7:0] <= spn_pkg::STN_MAX && hwdata[7:0] != 8'h00)
                  stn_reg <= hwdata[7:0]; // [RQ11]
            spn_pkg::OFS_RTS:     rts_reg <= hwdata[15:0];
            spn_pkg::OFS_TMO:     tmo_reg <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // Bit-rate divider [RQ3] [RQ20]
   logic [15:0] bdiv;
   logic        tick16;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bdiv   <= 16'h0000;
         tick16 <= 1'b0;
      end else if (bdiv >= spn_pkg::spn_div(ctrl_reg[2:0])) begin
         bdiv   <= 16'h0000;
         tick16 <= 1'b1;
      end else begin
         bdiv   <= bdiv + 16'h0001;
         tick16 <= 1'b0;
      end
   end

   // Millisecond tick for delays and timeout
   logic [15:0] mscnt;
   logic        mstick;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mscnt  <= 16'h0000;
         mstick <= 1'b0;
      end else begin
         mstick <= (mscnt == 16'(spn_pkg::CYC_PER_MS - 1));
         mscnt  <= (mscnt == 16'(spn_pkg::CYC_PER_MS - 1)) ? 16'h0000 : mscnt + 16'h0001;
      end
   end

   // Transmit sequence with RTS keying
   typedef enum logic [2:0] {S_IDLE, S_RTSON, S_SEND, S_RTSOFF, S_WAIT} spn_seq_t;
   spn_seq_t   seq;
   logic [15:0] dly;
   logic        tx_start;
   logic        tx_busy;
   logic        txline;
   logic        rx_done;
   logic [7:0]  rx_data;
   logic        rx_perr;
   logic        rx_ferr;

   wire if422 = ctrl_reg[spn_pkg::CTRL_IF422];
   wire rxline = if422 ? rxd422 : rxd232;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seq      <= S_IDLE;
         dly      <= 16'h0000;
         tx_start <= 1'b0;
         rts      <= 1'b0;
      end else begin
         tx_start <= 1'b0;
         unique case (seq)
            S_IDLE: if (txfull_reg) begin
               seq <= S_RTSON;
               rts <= 1'b1;
               dly <= rts_reg;
            end
            S_RTSON: if (dly == 16'h0000) seq <= S_SEND; // [RQ7]
               else if (mstick) dly <= dly - 16'h0001;
            S_SEND: if (!tx_busy && !tx_start) begin
               if (txfull_reg) tx_start <= 1'b1;
               else if (last_reg) begin
                  seq <= S_RTSOFF;
                  dly <= rts_reg;
               end
            end
            S_RTSOFF: if (dly == 16'h0000) begin // [RQ8]
               rts <= 1'b0;
               seq <= master_reg ? S_WAIT : S_IDLE;
               dly <= tmo_reg;
            end else if (mstick) dly <= dly - 16'h0001;
            S_WAIT: if (rx_done || dly == 16'h0000) seq <= S_IDLE; // [RQ9]
               else if (mstick) dly <= dly - 16'h0001;
            default: seq <= S_IDLE;
         endcase
      end
   end

   // Line drivers, one interface at a time [RQ16]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         txd232    <= 1'b1;
         txd422    <= 1'b1;
         txd422_oe <= 1'b0;
      end else begin
         txd232    <= if422 ? 1'b1 : txline;
         txd422    <= if422 ? txline : 1'b1;
         txd422_oe <= if422 & rts;
      end
   end

   // Master/slave role and data flags [RQ1] [RQ10] [RQ13] [RQ14]
   wire tmo_hit = seq == S_WAIT && dly == 16'h0000 && !rx_done;
   wire resp_end = seq == S_WAIT && (rx_done || dly == 16'h0000);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         master_reg <= 1'b0;
         last_reg   <= 1'b0;
      end else begin
         if (cmd_wr && hwdata[spn_pkg::CMD_MASTER] && stn_reg == spn_pkg::STN_MASTER)
            master_reg <= 1'b1;
         else if (resp_end || (seq == S_RTSOFF && dly == 16'h0000 && !master_reg))
            master_reg <= master_reg & ~resp_end;
         if (cmd_wr && hwdata[spn_pkg::CMD_TXLAST]) last_reg <= 1'b1;
         else if (seq == S_RTSOFF) last_reg <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         txd_reg    <= 8'h00;
         txfull_reg <= 1'b0;
      end else if (wr && ap_adr == spn_pkg::OFS_TXD && !txfull_reg) begin
         txd_reg    <= hwdata[7:0];
         txfull_reg <= 1'b1;
      end else if (tx_start) txfull_reg <= 1'b0;
   end

   // Receive flags, set wins over clear; first byte station match [RQ19]
   wire rd_rxd = ap_re && !hreadyout && ap_adr == spn_pkg::OFS_RXD;
   wire clr = cmd_wr && hwdata[spn_pkg::CMD_CLRERR];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rxd_reg <= 8'h00;
         rxval_reg <= 1'b0;
         perr_reg <= 1'b0;
         ferr_reg <= 1'b0;
         tmoerr_reg <= 1'b0;
         rxadr_reg <= 1'b0;
         rxfirst_reg <= 1'b1;
      end else begin
         if (rx_done) begin
            rxd_reg <= rx_data;
            rxval_reg <= 1'b1;
            rxfirst_reg <= 1'b0;
            if (rxfirst_reg) rxadr_reg <= (rx_data == stn_reg);
         end else if (rd_rxd) rxval_reg <= 1'b0;
         if (cmd_wr && hwdata[spn_pkg::CMD_TXGO]) rxfirst_reg <= 1'b1;
         perr_reg <= (rx_done & rx_perr) | (perr_reg & ~clr);
         ferr_reg <= (rx_done & rx_ferr) | (ferr_reg & ~clr);
         tmoerr_reg <= tmo_hit | (tmoerr_reg & ~clr); // [RQ9]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hrdata <= 32'h0000_0000;
      else if (ap_re && !hreadyout) begin
         unique case (ap_adr)
            spn_pkg::OFS_CTRL:    hrdata <= {23'h0, ctrl_reg};
            spn_pkg::OFS_STATION: hrdata <= {24'h0, stn_reg};
            spn_pkg::OFS_RTS:     hrdata <= {16'h0, rts_reg};
            spn_pkg::OFS_TMO:     hrdata <= {16'h0, tmo_reg};
            spn_pkg::OFS_RXD:     hrdata <= {24'h0, rxd_reg};
            spn_pkg::OFS_STAT:    hrdata <= {24'h0, rxadr_reg, rts, master_reg,
                                      tmoerr_reg, ferr_reg, perr_reg, rxval_reg, ~txfull_reg};
            default:              hrdata <= 32'h0000_0000;
         endcase
      end
   end

   spn_tx u_tx (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick16  (tick16),
      .stop2   (ctrl_reg[spn_pkg::CTRL_STOP2]), // [RQ5]
      .par     (par),
      .start   (tx_start),
      .data    (txd_reg), // RTU binary, ASCII hex encoded by software [RQ2] [RQ15]
      .busy    (tx_busy),
      .txd     (txline)
   );

   spn_rx u_rx (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick16  (tick16),
      .par     (par),
      .rxd     (rxline),
      .done    (rx_done),
      .data    (rx_data),
      .perr    (rx_perr),
      .ferr    (rx_ferr)
   );

   property p_rts_off;
      @(posedge hclk) disable iff (!hresetn)
      (seq == S_SEND && $past(seq) == S_RTSON) |-> rts;
   endproperty
   a_rts_off: assert property (p_rts_off) else $error("rts low while sending"); // [RQ7]
   property p_tmo;
      @(posedge hclk) disable iff (!hresetn) tmo_hit |=> tmoerr_reg;
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout not logged"); // [RQ9]
   property p_one_if;
      @(posedge hclk) disable iff (!hresetn) txd422_oe |-> txd232;
   endproperty
   a_one_if: assert property (p_one_if) else $error("both interfaces driven"); // [RQ16]
   property p_slave_back;
      @(posedge hclk) disable iff (!hresetn)
      resp_end && !(cmd_wr && hwdata[spn_pkg::CMD_MASTER]) |=> !master_reg;
   endproperty
   a_slave_back: assert property (p_slave_back) else $error("stayed master"); // [RQ14]
   property p_master_stn;
      @(posedge hclk) disable iff (!hresetn)
      $rose(master_reg) |-> $past(stn_reg) == spn_pkg::STN_MASTER;
   endproperty
   a_master_stn: assert property (p_master_stn) else $error("master on wrong station"); // [RQ10]
   property p_rts_fall;
      @(posedge hclk) disable iff (!hresetn)
      $fell(rts) |-> $past(seq) == S_RTSOFF && $past(dly) == 16'h0000;
   endproperty
   a_rts_fall: assert property (p_rts_fall) else $error("rts dropped before hold"); // [RQ8]
   property p_stn_range;
      @(posedge hclk) disable iff (!hresetn)
      stn_reg != 8'h00 && stn_reg <= spn_pkg::STN_MAX;
   endproperty
   a_stn_range: assert property (p_stn_range) else $error("station out of range"); // [RQ11]
   c_tx: cover property (@(posedge hclk) tx_start);
   c_rx: cover property (@(posedge hclk) rx_done);
   c_tmo: cover property (@(posedge hclk) tmo_hit);
endmodule

// ==== tb/spn_peer.sv ====
`timescale 1ns/1ns
module spn_peer (
   // Clock and line format
   input  wire logic        hclk,
   input  wire logic [31:0] bitc,
   input  wire logic [1:0]  par,
   input  wire logic        stop2,
   // Serial lines
   input  wire logic        line,
   output logic             rxd
);
   logic [9:0] got_q[$];
   logic [7:0] sh;
   logic       pb;
   logic       sok;

   // Sole slave on the link: two devices, station unique
   // Idle line sits at the pull-up level
   initial rxd = 1'h1;

   // Mid-bit sampling at the shared rate
   always begin
      @(negedge line);
      repeat (bitc / 2) @(posedge hclk);
      for (int i = 0; i < 8; i++) begin
         repeat (bitc) @(posedge hclk);
         sh[i] = line;
      end
      pb = 1'h0;
      if (par != 2'h0) begin
         repeat (bitc) @(posedge hclk);
         pb = line;
      end
      repeat (bitc) @(posedge hclk);
      sok = line;
      if (stop2) begin
         repeat (bitc) @(posedge hclk);
         sok = sok & line;
      end
      got_q.push_back({sok, pb, sh});
   end

   // Host side request, optionally corrupted
   task automatic send(input logic [7:0] d, input logic bp, input logic bs);
      rxd <= 1'h0;
      repeat (bitc) @(posedge hclk);
      for (int i = 0; i < 8; i++) begin
         rxd <= d[i];
         repeat (bitc) @(posedge hclk);
      end
      if (par != 2'h0) begin
         rxd <= (^d) ^ (par == 2'h2) ^ bp;
         repeat (bitc) @(posedge hclk);
      end
      rxd <= ~bs;
      repeat (bitc) @(posedge hclk);
      rxd <= 1'h1;
      if (stop2) repeat (bitc) @(posedge hclk);
   endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
module testbench;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        txd232;
   logic        txd422;
   logic        txd422_oe;
   logic        rts;
   logic        rxd;
   logic        line;
   logic        sel422;
   logic [1:0]  par;
   logic        stop2;
   logic [31:0] rd;
   logic [7:0]  d;
   logic [9:0]  exp_q[$];
   int          bitc;
   int          fails;
   int          checks_done;
   int          cyc;
   int          seed;
   int          n;
   int          brt[3] = '{9600, 19200, 38400};

   spn_port i_spn_port (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .txd232(txd232),
      .rxd232(rxd), .txd422(txd422), .txd422_oe(txd422_oe), .rxd422(rxd), .rts(rts)
   );
   spn_peer i_spn_peer (
      .hclk(hclk), .bitc(bitc), .par(par), .stop2(stop2), .line(line), .rxd(rxd)
   );
   // Released RS-422 driver reads as mark
   assign line = sel422 ? (txd422_oe ? txd422 : 1'h1) : txd232;

   initial begin
      hclk = 1'h0;
      forever #50 hclk = ~hclk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      checks_done++;
      if (seen !== ex) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, ex, seen);
      end
   endtask

   task automatic results;
      if (fails == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge hclk) begin
      cyc++;
      if (hresetn === 1'h1) begin
         chk("idle side", {31'h0, sel422 ? txd232 : txd422_oe}, {31'h0, sel422});
      end
      if (cyc == 100000) begin
         fails++;
         results;
      end
   end

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'h1;
      htrans <= 2'h2;
      haddr  <= {24'h00_0000, a};
      hwrite <= wr;
      hsize  <= 3'h2;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      rd = hrdata;
   endtask

   task automatic ctrl(input logic [2:0] sel, input logic proto);
      bitc = (spn_pkg::CLK_HZ / (brt[sel - 3'h2] * spn_pkg::OVS)) * spn_pkg::OVS;
      ahb(1'h1, spn_pkg::OFS_CTRL, 32'({sel422, 1'h0, proto, par, stop2, sel}));
   endtask

   task automatic tx_one(input int dly);
      int         fb;
      int         lo;
      int         hi;
      logic [9:0] ev;
      fb = 10 + int'(par != 2'h0) + int'(stop2);
      lo = (dly > 0) ? (dly - 1) * 10000 : 0;
      hi = (dly > 0) ? dly * 10000 + bitc : bitc / 2;
      d  = 8'($random(seed));
      exp_q.push_back({1'h1, (par == 2'h0) ? 1'h0 : ((^d) ^ (par == 2'h2)), d});
      ahb(1'h1, spn_pkg::OFS_TXD, {24'h00_0000, d});
      ahb(1'h1, spn_pkg::OFS_CMD, 32'h0000_0004);
      for (n = 0; n < 30000 && line !== 1'h0; n++) @(posedge hclk);
      chk("rts on", 32'(rts === 1'h1 && n >= lo && n <= hi + bitc), 32'h1);
      for (n = 0; n < 60000 && rts !== 1'h0; n++) @(posedge hclk);
      chk("rts off", 32'(n >= fb * bitc + lo - bitc / 2 && n <= fb * bitc + hi), 32'h1);
      ev = exp_q.pop_front();
      chk("frames", 32'(i_spn_peer.got_q.size()), 32'h1);
      if (i_spn_peer.got_q.size() > 0) begin
         chk("frame", {22'h0, i_spn_peer.got_q.pop_front()}, {22'h0, ev});
      end
   endtask

   task automatic rx_one(input logic bp, input logic bs);
      d = 8'($random(seed));
      ahb(1'h1, spn_pkg::OFS_CMD, 32'h0000_0002);
      i_spn_peer.send(d, bp, bs);
      repeat (bitc) @(posedge hclk);
      ahb(1'h0, spn_pkg::OFS_STAT, 32'h0);
      chk("rx errors", rd & 32'h0000_000C, {28'h0, bs, bp, 2'h0});
      chk("rx valid", {31'h0, rd[1]}, 32'h1);
      chk("rx station", {31'h0, rd[7]}, {31'h0, d == 8'h01});
      ahb(1'h0, spn_pkg::OFS_RXD, 32'h0);
      chk("rx data", {24'h0, rd[7:0]}, {24'h0, d});
      ahb(1'h1, spn_pkg::OFS_CMD, 32'h0000_0008);
      ahb(1'h0, spn_pkg::OFS_STAT, 32'h0);
      chk("rx clear", rd & 32'h0000_000E, 32'h0);
   endtask

   initial begin
      seed = 41662;
      fails = 0;
      checks_done = 0;
      cyc = 0;
      hresetn = 1'h0;
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      sel422 = 1'h0;
      par = 2'h0;
      stop2 = 1'h0;
      bitc = 1040;
      repeat (4) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      ahb(1'h0, spn_pkg::OFS_CTRL, 32'h0);
      chk("ctrl reset", rd, 32'h0000_0002);
      ahb(1'h0, spn_pkg::OFS_TMO, 32'h0);
      chk("timeout reset", rd, 32'h0000_0064);
      ahb(1'h0, spn_pkg::OFS_STAT, 32'h0);
      chk("stat reset", rd, 32'h0000_0001);
      ahb(1'h0, 8'h20, 32'h0);
      chk("unmapped", rd, 32'h0);
      chk("okay", {31'h0, hresp}, 32'h0);
      ahb(1'h1, spn_pkg::OFS_STATION, 32'h0);
      ahb(1'h1, spn_pkg::OFS_STATION, 32'h0000_005B);
      ahb(1'h0, spn_pkg::OFS_STATION, 32'h0);
      chk("station kept", rd, 32'h0000_0001);
      ahb(1'h1, spn_pkg::OFS_STATION, 32'h0000_005A);
      ahb(1'h1, spn_pkg::OFS_CMD, 32'h0000_0001);
      ahb(1'h0, spn_pkg::OFS_STATION, 32'h0);
      chk("station max", rd, 32'h0000_005A);
      ahb(1'h0, spn_pkg::OFS_STAT, 32'h0);
      chk("no master", {31'h0, rd[5]}, 32'h0);
      ahb(1'h1, spn_pkg::OFS_STATION, 32'h0000_0001);
      ahb(1'h1, spn_pkg::OFS_RTS, 32'h0000_0002);
      ahb(1'h1, spn_pkg::OFS_TMO, 32'h0000_0001);
      par = 2'h1;
      stop2 = 1'h1;
      ctrl(3'h4, 1'h0);
      tx_one(2);
      ahb(1'h1, spn_pkg::OFS_RTS, 32'h0000_0000);
      for (int k = 0; k < 3; k++) begin
         par = 2'(k);
         stop2 = (k == 1);
         ctrl(3'(4 - k / 2), k == 1);
         tx_one(0);
      end
      rx_one(1'h0, 1'h0);
      rx_one(1'h1, 1'h0);
      rx_one(1'h0, 1'h1);
      ahb(1'h1, spn_pkg::OFS_CMD, 32'h0000_0001);
      ahb(1'h0, spn_pkg::OFS_STAT, 32'h0);
      chk("master on", {31'h0, rd[5]}, 32'h1);
      tx_one(0);
      ahb(1'h0, spn_pkg::OFS_STAT, 32'h0);
      chk("awaiting reply", {30'h0, rd[5:4]}, 32'h2);
      for (n = 0; n < 1500 && rd[4] !== 1'h1; n++) begin
         repeat (16) @(posedge hclk);
         ahb(1'h0, spn_pkg::OFS_STAT, 32'h0);
      end
      chk("no reply", {30'h0, rd[5:4]}, 32'h1);
      ahb(1'h1, spn_pkg::OFS_CMD, 32'h0000_0008);
      sel422 = 1'h1;
      ctrl(3'h4, 1'h0);
      tx_one(0);
      results;
   end
endmodule
